/* File: roac_pkg.sv */
package roac_pkg;
  localparam int          NOUT          = 3;
  localparam int          CW            = 32;
  localparam logic [31:0] CNT_MAX       = 32'hffff_fffe;
  localparam logic [31:0] THR_RST       = 32'h0000_1388;
  localparam logic [31:0] THR_MIN       = 32'h0000_0001;
  localparam logic [15:0] EV_EDGE_M1    = 16'h0610;
  localparam logic [15:0] EV_EDGE_M2    = 16'h0710;
  localparam logic [15:0] EV_THR_M1     = 16'h061f;
  localparam logic [15:0] EV_THR_M2     = 16'h071f;
  localparam logic [15:0] EV_FRC_M1     = 16'h0628;
  localparam logic [15:0] EV_FRC_M2     = 16'h0728;
  localparam int          HIST_DEPTH    = 100;
  localparam int          HIST_AW       = 7;
  localparam int          CLK_HZ        = 20000000;
  localparam int          PRESS_MIN_MS  = 250;
  localparam int          PRESS_MAX_MS  = 1000;
  localparam int          PRESS_MIN_CYC = (CLK_HZ / 1000) * PRESS_MIN_MS;
  localparam int          PRESS_MAX_CYC = (CLK_HZ / 1000) * PRESS_MAX_MS;
  localparam int          TS_W          = 32;
  localparam int          EV_W          = TS_W + 16;
  localparam logic [1:0]  PRIO_MEDIUM   = 2'h1;
  typedef enum logic [1:0] {
    MODE_NONLATCH = 2'b00,
    MODE_LATCH    = 2'b01,
    MODE_DELAY    = 2'b10
  } roac_mode_t;
  typedef enum logic [1:0] {
    FB_OFF    = 2'b00,
    FB_ON     = 2'b01,
    FB_FREEZE = 2'b10
  } roac_fb_t;
  typedef enum logic [2:0] {
    APP_USER     = 3'b000,
    APP_MAINT    = 3'b001,
    APP_BREAKER  = 3'b010,
    APP_LIGHT    = 3'b011,
    APP_LOAD     = 3'b100
  } roac_app_t;
  typedef enum logic [1:0] {
    ST_POWERUP = 2'b00,
    ST_RUN     = 2'b01
  } roac_state_t;
endpackage

/* File: roac_hist_mem.sv */
`timescale 1ns/1ps
module roac_hist_mem (
  input  wire logic                         clk_sys_i,
  input  wire logic                         we_i,
  input  wire logic [roac_pkg::HIST_AW-1:0] waddr_i,
  input  wire logic [roac_pkg::EV_W-1:0]    wdata_i,
  input  wire logic [roac_pkg::HIST_AW-1:0] raddr_i,
  output logic      [roac_pkg::EV_W-1:0]    rdata_o
);
  import roac_pkg::*;
  // Event history storage with registered read data.
  logic [EV_W-1:0] mem [HIST_DEPTH];
  always_ff @(posedge clk_sys_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule

/* File: roac_relay_ctrl.sv */
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Operation
// - Three modes per output, default non-latching; output follows alarm.
// - Latching: output stays active after alarm clears until acknowledged.
// - Delayed: alarm holds output active for set duration, then drops.
// - Normally-open: active is high; normally-closed: active is low.
// - Maintenance force overrides normal operation; controller forces and unforces.
// - Per-output counter increments on every output state change.
// - Counter saturates at its maximum count.
// - Counters kept in non-volatile storage; clearable on request.
// - Per-counter threshold, minimum one, reset value 5000.
// - Counter reaching threshold raises that output's overrun alarm.
// - Activation edge logs event; codes from 0x0610 or 0x0710. Code drops it if a lower code falls in the same cycle.
// - Overrun alarms medium priority, manual or remote reset; from 0x061f.
// - Force/unforce change logs event; codes from 0x0628 or 0x0728. Code drops it if a lower code falls in the same cycle.
// - Per-output fallback choice: off, on or freeze.
// - Fallback applies at once on watchdog, link loss, supply loss, upgrade.
// - Predefined applications use fixed fallback: light freezes, others off.
// - Every event time-stamped; last 100 kept, older discarded.
// - Alarms latch until reset; auto-reset alarms clear when cause goes.
// - Manual reset by button held between 0.25 and 1 second.
// - Remote reset-alarms command clears remote-reset alarms.
// - Alarm priority fixed by design.
// - At power-on all outputs open before normal operation.
//////////////////////////////////////////////////////////////////////////////
module roac_relay_ctrl (
  input  wire logic                                  clk_sys_i,
  input  wire logic                                  rstn_i,
  input  wire logic                                  module_sel_i,
  input  wire logic [roac_pkg::NOUT-1:0]             alarm_i,
  input  wire logic [roac_pkg::NOUT-1:0]             ack_i,
  input  wire logic [2*roac_pkg::NOUT-1:0]           mode_i,
  input  wire logic [roac_pkg::NOUT-1:0]             nc_i,
  input  wire logic [roac_pkg::CW-1:0]               delay_cyc_i,
  input  wire logic [roac_pkg::NOUT-1:0]             force_en_i,
  input  wire logic [roac_pkg::NOUT-1:0]             force_val_i,
  input  wire logic [2*roac_pkg::NOUT-1:0]           fallback_i,
  input  wire logic [3*roac_pkg::NOUT-1:0]           app_i,
  input  wire logic                                  fault_watchdog_i,
  input  wire logic                                  fault_module_bus_link_i,
  input  wire logic                                  fault_supply_i,
  input  wire logic                                  fault_upgrade_i,
  input  wire logic                                  thr_we_i,
  input  wire logic [1:0]                            thr_sel_i,
  input  wire logic [roac_pkg::CW-1:0]               thr_val_i,
  input  wire logic [roac_pkg::NOUT-1:0]             cnt_clr_i,
  input  wire logic                                  nv_load_i,
  input  wire logic [roac_pkg::NOUT*roac_pkg::CW-1:0] nv_cnt_i,
  input  wire logic                                  button_i,
  input  wire logic                                  remote_reset_i,
  input  wire logic [roac_pkg::HIST_AW-1:0]          hist_raddr_i,
  output logic      [roac_pkg::NOUT-1:0]             relay_o,
  output logic      [roac_pkg::NOUT-1:0]             status_o,
  output logic      [roac_pkg::NOUT*roac_pkg::CW-1:0] cnt_o,
  output logic      [roac_pkg::NOUT-1:0]             thr_alarm_o,
  output logic      [1:0]                            thr_prio_o,
  output logic                                       ev_valid_o,
  output logic      [15:0]                           ev_code_o,
  output logic      [roac_pkg::EV_W-1:0]             hist_rdata_o,
  output logic      [roac_pkg::HIST_AW-1:0]          hist_wptr_o,
  output logic      [roac_pkg::HIST_AW-1:0]          hist_count_o
);
  import roac_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Run state: outputs are held open for one cycle after reset.
  roac_state_t state_ff, nxt_state;
  always_comb begin
    case (state_ff)
      ST_POWERUP: nxt_state = ST_RUN;
      ST_RUN:     nxt_state = ST_RUN;
      default:    nxt_state = ST_POWERUP;
    endcase
  end
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_ff <= ST_POWERUP;
    end else begin
      state_ff <= nxt_state;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Per-output status, counters and thresholds.
  logic [NOUT-1:0]    act_ff, nxt_act;
  logic [NOUT-1:0]    latch_ff, nxt_latch;
  logic [CW-1:0]      dly_ff [NOUT], nxt_dly [NOUT];
  logic [NOUT-1:0]    alarm_d_ff;
  logic [NOUT-1:0]    relay_ff, nxt_relay;
  logic [NOUT-1:0]    frc_d_ff;
  logic [CW-1:0]      cnt_ff [NOUT], nxt_cnt [NOUT];
  logic [CW-1:0]      thr_ff [NOUT], nxt_thr [NOUT];
  logic [NOUT-1:0]    thr_alarm_ff, nxt_thr_alarm;
  logic [NOUT-1:0]    armed_ff, nxt_armed;
  logic               fault;
  logic               clear_alarms;
  logic [NOUT-1:0]    edge_ev;
  logic [NOUT-1:0]    frc_ev;
  logic [NOUT-1:0]    thr_ev;
  roac_mode_t         md;
  roac_fb_t           fb;
  roac_app_t          ap;
  assign fault = fault_watchdog_i | fault_module_bus_link_i | fault_supply_i | fault_upgrade_i;
  always_comb begin
    for (int i = 0; i < NOUT; i++) begin
      md = roac_mode_t'(mode_i[2*i +: 2]);
      fb = roac_fb_t'(fallback_i[2*i +: 2]);
      ap = roac_app_t'(app_i[3*i +: 3]);
      nxt_latch[i] = latch_ff[i];
      nxt_dly[i] = dly_ff[i];
      nxt_act[i] = 1'b0;
      case (md)
        MODE_LATCH: begin
          if (alarm_i[i]) begin
            nxt_latch[i] = 1'b1;
          end else if (ack_i[i]) begin
            nxt_latch[i] = 1'b0;
          end
          nxt_act[i] = alarm_i[i] | nxt_latch[i];
        end
        MODE_DELAY: begin
          if (alarm_i[i] && !alarm_d_ff[i]) begin
            nxt_dly[i] = delay_cyc_i;
          end else if (dly_ff[i] != '0) begin
            nxt_dly[i] = dly_ff[i] - 32'h0000_0001;
          end
          nxt_act[i] = (nxt_dly[i] != '0);
        end
        default: begin
          nxt_act[i] = alarm_i[i];
        end
      endcase
      if (md != MODE_LATCH) begin
        nxt_latch[i] = 1'b0;
      end
      if (md != MODE_DELAY) begin
        nxt_dly[i] = '0;
      end
      if (force_en_i[i]) begin
        nxt_act[i] = force_val_i[i];
      end
      if (fault) begin
        if (ap == APP_LIGHT) begin
          nxt_act[i] = act_ff[i];
        end else if (ap != APP_USER) begin
          nxt_act[i] = 1'b0;
        end else if (fb == FB_ON) begin
          nxt_act[i] = 1'b1;
        end else if (fb == FB_FREEZE) begin
          nxt_act[i] = act_ff[i];
        end else begin
          nxt_act[i] = 1'b0;
        end
      end
      if (state_ff == ST_POWERUP) begin
        nxt_act[i] = 1'b0;
        nxt_relay[i] = 1'b0;
      end else begin
        nxt_relay[i] = nxt_act[i] ^ nc_i[i];
      end
    end
  end

  // Alarm clearing from the button window or the remote command.
  logic [31:0] press_ff, nxt_press;
  logic        btn_d_ff;
  logic        manual_clr;
  always_comb begin
    nxt_press = press_ff;
    manual_clr = 1'b0;
    if (button_i) begin
      if (press_ff != 32'hffff_ffff) begin
        nxt_press = press_ff + 32'h0000_0001;
      end
    end else begin
      nxt_press = '0;
      if (btn_d_ff && press_ff >= 32'(PRESS_MIN_CYC) && press_ff <= 32'(PRESS_MAX_CYC)) begin
        manual_clr = 1'b1;
      end
    end
  end
  assign clear_alarms = manual_clr | remote_reset_i;

  always_comb begin
    for (int i = 0; i < NOUT; i++) begin
      edge_ev[i] = nxt_act[i] & ~act_ff[i] & (state_ff == ST_RUN);
      frc_ev[i] = force_en_i[i] ^ frc_d_ff[i];
      nxt_cnt[i] = cnt_ff[i];
      if (nxt_relay[i] != relay_ff[i] && cnt_ff[i] < CNT_MAX) begin
        nxt_cnt[i] = cnt_ff[i] + 32'h0000_0001;
      end
      if (nv_load_i) begin
        nxt_cnt[i] = nv_cnt_i[CW*i +: CW];
      end
      nxt_armed[i] = armed_ff[i];
      if (cnt_clr_i[i]) begin
        nxt_cnt[i] = '0;
        nxt_armed[i] = 1'b1;
      end
      nxt_thr[i] = thr_ff[i];
      if (thr_we_i && thr_sel_i == 2'(i)) begin
        nxt_thr[i] = (thr_val_i < THR_MIN) ? THR_MIN : thr_val_i;
      end
      thr_ev[i] = 1'b0;
      nxt_thr_alarm[i] = thr_alarm_ff[i];
      if (clear_alarms) begin
        nxt_thr_alarm[i] = 1'b0;
      end
      if (armed_ff[i] && !cnt_clr_i[i] && cnt_ff[i] >= thr_ff[i]) begin
        nxt_thr_alarm[i] = 1'b1;
        nxt_armed[i] = 1'b0;
        thr_ev[i] = 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Event selection: one event per cycle, lowest code wins; the others are dropped.
  logic [15:0]     nxt_code;
  logic            nxt_ev;
  always_comb begin
    nxt_ev = 1'b0;
    nxt_code = '0;
    for (int i = NOUT - 1; i >= 0; i--) begin
      if (frc_ev[i]) begin
        nxt_ev = 1'b1;
        nxt_code = (module_sel_i ? EV_FRC_M2 : EV_FRC_M1) + 16'(i);
      end
    end
    for (int i = NOUT - 1; i >= 0; i--) begin
      if (thr_ev[i]) begin
        nxt_ev = 1'b1;
        nxt_code = (module_sel_i ? EV_THR_M2 : EV_THR_M1) + 16'(i);
      end
    end
    for (int i = NOUT - 1; i >= 0; i--) begin
      if (edge_ev[i]) begin
        nxt_ev = 1'b1;
        nxt_code = (module_sel_i ? EV_EDGE_M2 : EV_EDGE_M1) + 16'(i);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Time stamp and history pointers.
  logic [TS_W-1:0]    ts_ff, nxt_ts;
  logic [HIST_AW-1:0] wptr_ff, nxt_wptr;
  logic [HIST_AW-1:0] hcnt_ff, nxt_hcnt;
  always_comb begin
    nxt_ts = ts_ff + 32'h0000_0001;
    nxt_wptr = wptr_ff;
    nxt_hcnt = hcnt_ff;
    if (ev_valid_o) begin
      nxt_wptr = (wptr_ff == 7'(HIST_DEPTH - 1)) ? '0 : wptr_ff + 7'h01;
      if (hcnt_ff != 7'(HIST_DEPTH)) begin
        nxt_hcnt = hcnt_ff + 7'h01;
      end
    end
  end

  roac_hist_mem u_hist (
    .clk_sys_i (clk_sys_i),
    .we_i      (ev_valid_o),
    .waddr_i   (wptr_ff),
    .wdata_i   ({ts_ff, ev_code_o}),
    .raddr_i   (hist_raddr_i),
    .rdata_o   (hist_rdata_o)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Registers.
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      act_ff       <= '0;
      latch_ff     <= '0;
      alarm_d_ff   <= '0;
      relay_ff     <= '0;
      frc_d_ff     <= '0;
      thr_alarm_ff <= '0;
      armed_ff     <= '1;
      press_ff     <= '0;
      btn_d_ff     <= 1'b0;
      ts_ff        <= '0;
      wptr_ff      <= '0;
      hcnt_ff      <= '0;
      ev_valid_o   <= 1'b0;
      ev_code_o    <= '0;
      relay_o      <= '0;
      status_o     <= '0;
      thr_alarm_o  <= '0;
      thr_prio_o   <= PRIO_MEDIUM;
      cnt_o        <= '0;
      hist_wptr_o  <= '0;
      hist_count_o <= '0;
      for (int i = 0; i < NOUT; i++) begin
        dly_ff[i] <= '0;
        cnt_ff[i] <= '0;
        thr_ff[i] <= THR_RST;
      end
    end else begin
      act_ff       <= nxt_act;
      latch_ff     <= nxt_latch;
      alarm_d_ff   <= alarm_i;
      relay_ff     <= nxt_relay;
      frc_d_ff     <= force_en_i;
      thr_alarm_ff <= nxt_thr_alarm;
      armed_ff     <= nxt_armed;
      press_ff     <= nxt_press;
      btn_d_ff     <= button_i;
      ts_ff        <= nxt_ts;
      wptr_ff      <= nxt_wptr;
      hcnt_ff      <= nxt_hcnt;
      ev_valid_o   <= nxt_ev;
      ev_code_o    <= nxt_code;
      relay_o      <= nxt_relay;
      status_o     <= nxt_act;
      thr_alarm_o  <= nxt_thr_alarm;
      thr_prio_o   <= PRIO_MEDIUM;
      hist_wptr_o  <= nxt_wptr;
      hist_count_o <= nxt_hcnt;
      for (int i = 0; i < NOUT; i++) begin
        dly_ff[i] <= nxt_dly[i];
        cnt_ff[i] <= nxt_cnt[i];
        thr_ff[i] <= nxt_thr[i];
        cnt_o[CW*i +: CW] <= nxt_cnt[i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions.
  a_nonlatch_follow: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (state_ff == ST_RUN && mode_i[1:0] == 2'b00 && !force_en_i[0] && !fault)
      |=> (status_o[0] == $past(alarm_i[0])))
    else $error("Non-latching output does not follow alarm.");
  a_latch_hold: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (latch_ff[2] && mode_i[5:4] == 2'b01 && !ack_i[2] && !force_en_i[2] && !fault)
      |=> status_o[2])
    else $error("Latched output dropped without acknowledge.");
  a_polarity_map: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (state_ff == ST_RUN) |=> (relay_o == (status_o ^ $past(nc_i))))
    else $error("Relay level does not match contact type.");
  a_force_wins: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (state_ff == ST_RUN && force_en_i[1] && !fault) |=> (status_o[1] == $past(force_val_i[1])))
    else $error("Forced state not applied.");
  a_cnt_sat: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    cnt_ff[0] <= CNT_MAX || $past(nv_load_i))
    else $error("Counter passed its maximum.");
  a_cnt_clear: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    cnt_clr_i[2] |=> (cnt_o[3*CW-1:2*CW] == '0))
    else $error("Counter clear did not zero the counter.");
  a_fb_on: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (fault && app_i[2:0] == 3'b000 && fallback_i[1:0] == 2'b01 && state_ff == ST_RUN)
      |=> status_o[0])
    else $error("Fallback on not applied.");
  a_powerup_open: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    $rose(state_ff == ST_RUN) |-> (relay_o == '0))
    else $error("Outputs not open at power-on.");
  a_remote_clear: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (remote_reset_i && !(armed_ff != '0 && thr_ev != '0)) |=> (thr_alarm_o == '0))
    else $error("Remote reset did not clear alarms.");
  c_latch_ack: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
    latch_ff[2] ##1 ack_i[2] && !alarm_i[2]);
  c_thr_alarm: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) $rose(thr_alarm_o[0]));
  c_fault_fb: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) $rose(fault));
endmodule

/* File: roac_partner.sv */
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Relay driver and remote controller on the far side of the block.
module roac_partner (
  input  wire logic       clk_sys_i,
  input  wire logic [2:0] relay_i,
  output logic            remote_reset_o,
  output logic [2:0]      coil_o
);
  initial remote_reset_o = 1'b0;
  always @(posedge clk_sys_i) coil_o <= relay_i;
  // Sends the reset-alarms command after a chosen wait.
  task automatic send_reset(input int wait_cyc);
    repeat (wait_cyc) @(negedge clk_sys_i);
    remote_reset_o = 1'b1;
    @(negedge clk_sys_i);
    remote_reset_o = 1'b0;
  endtask
endmodule

/* File: roac_relay_ctrl_tb.sv */
`timescale 1ns/1ps
module roac_relay_ctrl_tb;
  import roac_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        rstn_i    = 1'b0;
  logic        msel      = 1'b0;
  logic [2:0]  alarm     = 3'h0;
  logic [2:0]  ack       = 3'h0;
  logic [5:0]  mode      = 6'h0;
  logic [2:0]  nc        = 3'h2;
  logic [31:0] dly       = 32'h0;
  logic [2:0]  fen       = 3'h0;
  logic [2:0]  fval      = 3'h0;
  logic [5:0]  fb        = 6'h0;
  logic [8:0]  app       = 9'h0;
  logic [3:0]  fault     = 4'h0;
  logic        thr_we    = 1'b0;
  logic [1:0]  thr_sel   = 2'h0;
  logic [31:0] thr_val   = 32'h0;
  logic [2:0]  clr       = 3'h0;
  logic        nv_load   = 1'b0;
  logic [95:0] nv_cnt    = 96'h0;
  logic [6:0]  raddr     = 7'h0;
  logic        btn       = 1'b0;
  logic        rrst;
  logic [2:0]  relay, status, thr_alarm;
  logic [95:0] cnt;
  logic [1:0]  prio;
  logic        ev_v;
  logic [15:0] ev_code;
  logic [47:0] hrd;
  logic [6:0]  wptr, hcnt;
  logic [15:0] last_code = 16'h0;
  int          n_ev = 0;
  int          n_mismatch = 0;
  int          samples_checked = 0;

  always #25 clk_sys_i = ~clk_sys_i;

  roac_relay_ctrl i_roac_relay_ctrl (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .module_sel_i(msel), .alarm_i(alarm),
    .ack_i(ack), .mode_i(mode), .nc_i(nc), .delay_cyc_i(dly), .force_en_i(fen),
    .force_val_i(fval), .fallback_i(fb), .app_i(app), .fault_watchdog_i(fault[0]),
    .fault_module_bus_link_i(fault[1]), .fault_supply_i(fault[2]),
    .fault_upgrade_i(fault[3]), .thr_we_i(thr_we), .thr_sel_i(thr_sel),
    .thr_val_i(thr_val), .cnt_clr_i(clr), .nv_load_i(nv_load), .nv_cnt_i(nv_cnt),
    .button_i(btn), .remote_reset_i(rrst), .hist_raddr_i(raddr), .relay_o(relay),
    .status_o(status), .cnt_o(cnt), .thr_alarm_o(thr_alarm), .thr_prio_o(prio),
    .ev_valid_o(ev_v), .ev_code_o(ev_code), .hist_rdata_o(hrd), .hist_wptr_o(wptr),
    .hist_count_o(hcnt));

  roac_partner i_roac_partner (
    .clk_sys_i(clk_sys_i), .relay_i(relay), .remote_reset_o(rrst), .coil_o());

  always @(posedge clk_sys_i) begin
    if (ev_v === 1'b1) begin
      last_code <= ev_code;
      n_ev <= n_ev + 1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask

  task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_ev(input logic [15:0] exp);
    chk(48'(last_code), 48'(exp), "event code");
  endtask

  task automatic done_test(input string name);
    $display("test %s ended, mismatches %0d", name, n_mismatch);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wait_thr(input int idx);
    for (int i = 0; i < 8 && thr_alarm[idx] !== 1'b1; i++) tick(1);
    if (thr_alarm[idx] !== 1'b1) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: overrun alarm never rose", $time);
      results();
    end
  endtask

  task automatic pulse_nv(input logic [31:0] v2);
    nv_cnt = {v2, 64'h0};
    nv_load = 1'b1;
    tick(1);
    nv_load = 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #(50 * 20000);
    n_mismatch++;
    $display("CHECK FAILED at %0t: run timed out", $time);
    results();
  end

  initial begin
    logic [31:0] ts0;
    tick(6);
    chk(48'(relay), 48'h0, "relay in reset");
    chk(48'(prio), 48'(PRIO_MEDIUM), "priority");
    rstn_i = 1'b1;
    tick(1);
    chk(48'(relay), 48'h0, "relay at power-up");
    tick(2);
    chk(48'(relay), 48'h2, "idle relays");
    done_test("power-up");
    pulse_nv(32'h0000_1387);
    alarm = 3'h4;
    tick(1);
    chk(48'(cnt[95:64]), 48'(THR_RST), "count at threshold");
    wait_thr(2);
    chk(48'(thr_alarm), 48'h4, "overrun at default");
    tick(2);
    chk_ev(EV_THR_M1 + 16'h2);
    i_roac_partner.send_reset(2);
    tick(1);
    chk(48'(thr_alarm), 48'h0, "remote reset");
    alarm = 3'h0;
    tick(1);
    pulse_nv(CNT_MAX - 32'h1);
    alarm = 3'h4;
    tick(1);
    alarm = 3'h0;
    tick(2);
    chk(48'(cnt[95:64]), 48'(CNT_MAX), "saturated");
    clr = 3'h4;
    tick(1);
    clr = 3'h0;
    tick(1);
    chk(48'(cnt[95:64]), 48'h0, "cleared");
    done_test("counter");
    alarm = 3'h1;
    tick(1);
    chk(48'({relay[0], status[0]}), 48'h3, "follow on");
    chk(48'(cnt[31:0]), 48'h1, "count on");
    tick(1);
    chk_ev(EV_EDGE_M1);
    alarm = 3'h0;
    tick(1);
    chk(48'({relay[0], status[0]}), 48'h0, "follow off");
    chk(48'(cnt[31:0]), 48'h2, "count off");
    alarm = 3'h2;
    tick(2);
    chk(48'({relay[1], status[1]}), 48'h1, "closed contact active");
    chk_ev(EV_EDGE_M1 + 16'h1);
    alarm = 3'h0;
    tick(2);
    chk(48'(relay[1]), 48'h1, "closed contact idle");
    mode = 6'h10;
    alarm = 3'h4;
    tick(2);
    alarm = 3'h0;
    tick(2);
    chk(48'(status[2]), 48'h1, "latched");
    ack = 3'h4;
    tick(1);
    ack = 3'h0;
    tick(1);
    chk(48'(status[2]), 48'h0, "acknowledged");
    mode = 6'h02;
    dly = 32'h14;
    alarm = 3'h1;
    tick(1);
    alarm = 3'h0;
    tick(19);
    chk(48'(status[0]), 48'h1, "delay holds");
    tick(1);
    chk(48'(status[0]), 48'h0, "delay over");
    done_test("modes");
    mode = 6'h0;
    msel = 1'b1;
    fen = 3'h2;
    tick(2);
    chk_ev(EV_FRC_M2 + 16'h1);
    alarm = 3'h2;
    tick(2);
    chk(48'(status[1]), 48'h0, "forced off");
    alarm = 3'h0;
    tick(1);
    msel = 1'b0;
    fen = 3'h0;
    tick(2);
    chk_ev(EV_FRC_M1 + 16'h1);
    done_test("force");
    thr_val = 32'h0;
    thr_we = 1'b1;
    tick(1);
    thr_we = 1'b0;
    clr = 3'h1;
    tick(1);
    clr = 3'h0;
    alarm = 3'h1;
    wait_thr(0);
    chk(48'(cnt[31:0]), 48'h1, "threshold one");
    tick(2);
    chk_ev(EV_THR_M1);
    i_roac_partner.send_reset(0);
    alarm = 3'h0;
    tick(3);
    chk(48'(thr_alarm), 48'h0, "raised once");
    clr = 3'h1;
    tick(1);
    clr = 3'h0;
    alarm = 3'h1;
    wait_thr(0);
    chk(48'(thr_alarm), 48'h1, "re-armed");
    btn = 1'b1;
    tick(4);
    btn = 1'b0;
    tick(2);
    chk(48'(thr_alarm), 48'h1, "short press ignored");
    alarm = 3'h0;
    i_roac_partner.send_reset(1);
    tick(1);
    chk(48'(thr_alarm), 48'h0, "remote reset again");
    done_test("threshold");
    fb = 6'h15;
    app = {APP_LOAD, APP_LIGHT, APP_USER};
    for (int k = 0; k < 4; k++) begin
      alarm = 3'h6;
      tick(2);
      chk(48'(relay), 48'h4, "before fault");
      fault = 4'(4'h1 << k);
      alarm = 3'h0;
      tick(1);
      chk(48'(relay), 48'h1, "fallback");
      fault = 4'h0;
      tick(2);
    end
    done_test("fallback");
    raddr = 7'h0;
    tick(2);
    chk(48'(hrd[15:0]), 48'(EV_EDGE_M1 + 16'h2), "oldest entry");
    ts0 = hrd[47:16];
    raddr = 7'h1;
    tick(2);
    chk(48'(hrd[15:0]), 48'(EV_THR_M1 + 16'h2), "second entry");
    chk(48'(hrd[47:16] > ts0), 48'h1, "time order");
    chk(48'(hcnt), 48'(n_ev), "entry count");
    for (int k = 0; k < 100; k++) begin
      alarm = 3'h1;
      tick(2);
      alarm = 3'h0;
      tick(2);
    end
    chk(48'(hcnt), 48'(HIST_DEPTH), "full history");
    chk(48'(wptr), 48'(n_ev % HIST_DEPTH), "oldest overwritten");
    done_test("history");
    results();
  end
endmodule
